// File: src/cssp_params.svh
// Purpose: constants for the clocked serial shift port
// Assumes: printed offsets are register indices; byte address is four times the index
// Notes: definitions only
`ifndef CSSP_PARAMS_SVH
`define CSSP_PARAMS_SVH
`define CSSP_IDX_PORT_FUNC 12'h004
`define CSSP_IDX_CTRL_A 12'h005
`define CSSP_IDX_DATA_LO 12'h006
`define CSSP_IDX_DATA_HI 12'h007
`define CSSP_IDX_ASSORTED 12'h00c
`define CSSP_IDX_CTRL_B 12'h028
`define CSSP_IDX_CMD 12'h030
`define CSSP_IDX_STATUS 12'h031
`define CSSP_RESP_OKAY 2'h0
`define CSSP_RESP_SLVERR 2'h2
`define CSSP_NIB_ZERO 4'h0
`define CSSP_BYTE_ZERO 8'h00
`define CSSP_CNT_ZERO 3'h0
`define CSSP_CNT_LAST 3'h7
`define CSSP_BIT_PIN_SEL 3
`define CSSP_BIT_IDLE_LVL 1
`define CSSP_BIT_DOUBLE 0
`define CSSP_BIT_IRQ 2
`define CSSP_MODE_SYSCLK 3'h6
`define CSSP_MODE_EXTCLK 3'h7
`define CSSP_PDIV_W 13
`define CSSP_PDIV_ONE 13'h0001
`define CSSP_PDIV_ZERO 13'h0000
`define CSSP_PDIV_TOP 13'h0800
`endif

// File: src/cssp_pkg.sv
// Purpose: types for the clocked serial shift port
// Assumes: nothing
// Notes: constants live in cssp_params.svh
package cssp_pkg;
   typedef enum logic [1:0] {CSSP_IDLE, CSSP_CLK_WAIT, CSSP_XFER, CSSP_CONT} cssp_state_type;
   typedef enum logic [1:0] {CSSP_PM_CLK_ONLY, CSSP_PM_TX, CSSP_PM_RX, CSSP_PM_TXRX} cssp_pmode_type;
endpackage

// File: src/cssp_tick_gen.sv
// Purpose: transmit clock generator: half-period tick from prescaler or system clock
// Assumes: one aclk equals one instruction cycle
// Notes: tick pulses once per half period of the transmit clock
`timescale 1ns/1ps
`include "cssp_params.svh"
module cssp_tick_gen
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic dbl,
   output logic tick
);
   logic [`CSSP_PDIV_W-1:0] cnt;
   logic [`CSSP_PDIV_W-1:0] next_cnt;
   logic [`CSSP_PDIV_W-1:0] limit;

   // half period equals ratio; ratio 2048 >> 2*sel, doubled by dbl; system clock mode ratio 1, never doubled
   function automatic logic [`CSSP_PDIV_W-1:0] ratio(input logic [2:0] s, input logic d);
      logic [`CSSP_PDIV_W-1:0] base;
      base = `CSSP_PDIV_TOP >> {s[2:0], 1'b0};
      if (s == `CSSP_MODE_SYSCLK)
         base = `CSSP_PDIV_ONE;
      ratio = d && (s != `CSSP_MODE_SYSCLK) ? {base[`CSSP_PDIV_W-2:0], 1'b0} : base;
   endfunction

   always_comb
   begin
      limit = ratio(sel, dbl); // RULE12
      next_cnt = cnt + `CSSP_PDIV_ONE;
      if (!run || next_cnt >= limit)
         next_cnt = `CSSP_PDIV_ZERO;
      tick = run && (cnt + `CSSP_PDIV_ONE >= limit);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt <= `CSSP_PDIV_ZERO;
      else
         cnt <= next_cnt;
   end
endmodule

// File: src/cssp_serial_port.sv
// Purpose: clock-synchronous 8-bit serial shift port with AXI4-Lite registers
// Assumes: one aclk is one instruction cycle; pins synchronous to aclk
// Notes: behaviour listed below
// Notes on behaviour
// [RULE1] eight bits shift per transfer
// [RULE2] pin select set: port bits choose mode
// [RULE3] software rewrites control a after mode change
// [RULE4] any control a write reinitialises
// [RULE5] control a picks clock pin, port picks data pins
// [RULE6] clock from pin, prescaler or system clock
// [RULE7] data write loads, read returns received
// [RULE8] serial out undefined until driven or programmed
// [RULE9] start command activates, clears counter
// [RULE10] counter advances each rising transmit clock
// [RULE11] eighth clock or abort: clear, flag, stop; with external clock the eighth clock goes back to CSSP_CLK_WAIT instead
// [RULE12] prescaler ratios 2048 down to 2, doubled
// [RULE13] shift byte as two nibbles
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cssp_params.svh"
module cssp_serial_port
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe,
   output logic serial_irq_flag
);
   cssp_pkg::cssp_state_type state, next_state;
   logic [3:0] port_pin_function_select, next_port_pin_function_select;
   logic [3:0] serial_control_a, next_serial_control_a;
   logic [3:0] serial_control_b, next_serial_control_b;
   logic [3:0] assorted_control, next_assorted_control;
   logic [7:0] shift_reg, next_shift_reg;
   logic [2:0] octal_bit_counter, next_octal_bit_counter;
   logic next_serial_irq_flag;
   logic sck_lvl, next_sck_lvl;
   logic sck_prev, next_sck_prev;
   logic next_so_out, next_so_oe;
   logic aw_hold, next_aw_hold, w_hold, next_w_hold;
   logic [11:0] aw_idx, next_aw_idx;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic tick, ext_mode, int_run, rise, fall, wr_go, rd_go, wr_ok;
   logic wr_ctrl_a, start_cmd, tx_en, rx_en;
   cssp_pkg::cssp_pmode_type pmode;

   function automatic logic mapped(input logic [11:0] idx);
      mapped = idx == `CSSP_IDX_PORT_FUNC || idx == `CSSP_IDX_CTRL_A ||
         idx == `CSSP_IDX_DATA_LO || idx == `CSSP_IDX_DATA_HI ||
         idx == `CSSP_IDX_ASSORTED || idx == `CSSP_IDX_CTRL_B ||
         idx == `CSSP_IDX_CMD || idx == `CSSP_IDX_STATUS;
   endfunction

   cssp_tick_gen u_tick
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(int_run),
      .sel(serial_control_a[2:0]),
      .dbl(serial_control_b[`CSSP_BIT_DOUBLE]),
      .tick(tick)
   );

   always_comb
   begin
      pmode = cssp_pkg::cssp_pmode_type'(port_pin_function_select[1:0]); // RULE2
      tx_en = port_pin_function_select[0]; // RULE5
      rx_en = port_pin_function_select[1]; // RULE5
      ext_mode = serial_control_a[2:0] == `CSSP_MODE_EXTCLK; // RULE6
      int_run = !ext_mode && state != cssp_pkg::CSSP_IDLE; // RULE6
      s_axi_awready = !aw_hold;
      s_axi_wready = !w_hold;
      s_axi_arready = !s_axi_rvalid;
      next_aw_hold = aw_hold;
      next_aw_idx = aw_idx;
      next_w_hold = w_hold;
      next_w_data = w_data;
      next_w_strb = w_strb;
      if (s_axi_awvalid && !aw_hold)
      begin
         next_aw_hold = 1'b1;
         next_aw_idx = s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && !w_hold)
      begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      wr_go = aw_hold && w_hold && !s_axi_bvalid;
      wr_ok = wr_go && w_strb[0] && mapped(aw_idx);
      if (wr_go)
      begin
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
      end
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      if (wr_go)
      begin
         next_bvalid = 1'b1;
         next_bresp = mapped(aw_idx) ? `CSSP_RESP_OKAY : `CSSP_RESP_SLVERR;
      end
      rd_go = s_axi_arvalid && !s_axi_rvalid;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (rd_go)
      begin
         next_rvalid = 1'b1;
         next_rresp = mapped(s_axi_araddr[13:2]) ? `CSSP_RESP_OKAY : `CSSP_RESP_SLVERR;
         next_rdata = 32'h0000_0000;
         unique case (s_axi_araddr[13:2])
            `CSSP_IDX_DATA_LO: next_rdata[3:0] = shift_reg[3:0]; // RULE13
            `CSSP_IDX_DATA_HI: next_rdata[3:0] = shift_reg[7:4]; // RULE13
            `CSSP_IDX_ASSORTED: next_rdata[3:0] = assorted_control;
            `CSSP_IDX_CTRL_B: next_rdata[3:0] = serial_control_b;
            `CSSP_IDX_STATUS: next_rdata[6:0] = {state, octal_bit_counter, 1'b0,
               serial_irq_flag};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      wr_ctrl_a = wr_ok && aw_idx == `CSSP_IDX_CTRL_A;
      start_cmd = wr_ok && aw_idx == `CSSP_IDX_CMD && w_data[0];
      next_port_pin_function_select = port_pin_function_select;
      next_serial_control_a = serial_control_a;
      next_serial_control_b = serial_control_b;
      next_assorted_control = assorted_control;
      next_shift_reg = shift_reg;
      next_state = state;
      next_octal_bit_counter = octal_bit_counter;
      next_serial_irq_flag = serial_irq_flag;
      next_so_out = so_out;
      next_so_oe = so_oe;
      next_sck_lvl = sck_lvl;
      next_sck_prev = sck_in;
      if (wr_ok && aw_idx == `CSSP_IDX_PORT_FUNC)
         next_port_pin_function_select = w_data[3:0];
      if (wr_ctrl_a)
         next_serial_control_a = w_data[3:0];
      if (wr_ok && aw_idx == `CSSP_IDX_CTRL_B)
         next_serial_control_b = w_data[3:0];
      if (wr_ok && aw_idx == `CSSP_IDX_ASSORTED)
         next_assorted_control = w_data[3:0];
      if (wr_ok && aw_idx == `CSSP_IDX_DATA_LO)
         next_shift_reg[3:0] = w_data[3:0]; // RULE7 RULE13
      if (wr_ok && aw_idx == `CSSP_IDX_DATA_HI)
         next_shift_reg[7:4] = w_data[3:0]; // RULE7 RULE13
      if (wr_ok && aw_idx == `CSSP_IDX_STATUS && w_data[`CSSP_BIT_IRQ])
         next_serial_irq_flag = 1'b0;
      if (ext_mode)
      begin
         rise = sck_in && !sck_prev;
         fall = !sck_in && sck_prev;
      end
      else
      begin
         rise = tick && !sck_lvl;
         fall = tick && sck_lvl;
         if (tick && state != cssp_pkg::CSSP_IDLE)
            next_sck_lvl = !sck_lvl;
      end
      if (state != cssp_pkg::CSSP_XFER &&
         serial_control_a[`CSSP_BIT_PIN_SEL] && tx_en && wr_ok && aw_idx == `CSSP_IDX_CTRL_B)
      begin
         next_so_out = w_data[`CSSP_BIT_IDLE_LVL]; // RULE8
         next_so_oe = 1'b1; // RULE8
      end
      unique case (state)
         cssp_pkg::CSSP_IDLE:
         begin
            next_sck_lvl = 1'b1;
            if (start_cmd)
            begin
               next_state = cssp_pkg::CSSP_CLK_WAIT; // RULE9
               next_octal_bit_counter = `CSSP_CNT_ZERO; // RULE9
            end
         end
         cssp_pkg::CSSP_CLK_WAIT:
         begin
            if (start_cmd)
               next_octal_bit_counter = `CSSP_CNT_ZERO; // RULE9
            else if (fall && pmode == cssp_pkg::CSSP_PM_CLK_ONLY && !ext_mode)
               next_state = cssp_pkg::CSSP_CONT;
            else if (fall)
            begin
               next_state = cssp_pkg::CSSP_XFER;
               next_so_out = shift_reg[0]; // RULE1
               next_so_oe = tx_en;
            end
         end
         cssp_pkg::CSSP_XFER:
         begin
            if (fall && octal_bit_counter != `CSSP_CNT_ZERO)
               next_so_out = shift_reg[0]; // RULE1
            if (start_cmd)
            begin
               next_octal_bit_counter = `CSSP_CNT_ZERO; // RULE11
               next_serial_irq_flag = 1'b1; // RULE11
               next_state = cssp_pkg::CSSP_CLK_WAIT;
            end
            else if (rise)
            begin
               next_shift_reg = {rx_en ? si_in : 1'b0, shift_reg[7:1]}; // RULE1 RULE7
               next_octal_bit_counter = octal_bit_counter + 3'h1; // RULE10
               if (octal_bit_counter == `CSSP_CNT_LAST)
               begin
                  next_octal_bit_counter = `CSSP_CNT_ZERO; // RULE11
                  next_serial_irq_flag = 1'b1; // RULE11
                  next_state = ext_mode ? cssp_pkg::CSSP_CLK_WAIT : cssp_pkg::CSSP_IDLE;
               end
            end
         end
         cssp_pkg::CSSP_CONT:
            next_state = cssp_pkg::CSSP_CONT;
         default:
            next_state = cssp_pkg::CSSP_IDLE;
      endcase
      if (wr_ctrl_a)
      begin
         if (state == cssp_pkg::CSSP_XFER)
            next_serial_irq_flag = 1'b1; // RULE11
         next_state = cssp_pkg::CSSP_IDLE; // RULE4
         next_octal_bit_counter = `CSSP_CNT_ZERO; // RULE4
         next_sck_lvl = 1'b1;
      end
      sck_out = sck_lvl;
      sck_oe = next_serial_control_a[`CSSP_BIT_PIN_SEL] && !ext_mode; // RULE5
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= cssp_pkg::CSSP_IDLE;
         port_pin_function_select <= `CSSP_NIB_ZERO;
         serial_control_a <= `CSSP_NIB_ZERO;
         serial_control_b <= `CSSP_NIB_ZERO;
         assorted_control <= `CSSP_NIB_ZERO;
         shift_reg <= `CSSP_BYTE_ZERO;
         octal_bit_counter <= `CSSP_CNT_ZERO;
         serial_irq_flag <= 1'b0;
         sck_lvl <= 1'b1;
         sck_prev <= 1'b1;
         so_out <= 1'b0;
         so_oe <= 1'b0;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_idx <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CSSP_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `CSSP_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end
      else
      begin
         state <= next_state;
         port_pin_function_select <= next_port_pin_function_select;
         serial_control_a <= next_serial_control_a;
         serial_control_b <= next_serial_control_b;
         assorted_control <= next_assorted_control;
         shift_reg <= next_shift_reg;
         octal_bit_counter <= next_octal_bit_counter;
         serial_irq_flag <= next_serial_irq_flag;
         sck_lvl <= next_sck_lvl;
         sck_prev <= next_sck_prev;
         so_out <= next_so_out;
         so_oe <= next_so_oe;
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         aw_idx <= next_aw_idx;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end
endmodule

// File: verification/cssp_chk.sv
// Purpose: port checks for cssp_serial_port
// Assumes: sees the top ports only
// Notes: bound at the foot
`timescale 1ns/1ps
`include "cssp_params.svh"
module cssp_chk
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic so_oe,
   input wire logic serial_irq_flag
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic rd_status = 1'b0;
   // status word carries state and counter in bits 6 to 2, above the flag in bit 0
   always @(posedge aclk)
   begin
      if (s_axi_arvalid && s_axi_arready)
         rd_status <= s_axi_araddr[13:2] == `CSSP_IDX_STATUS;
   end
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
   a_addr_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second address taken");
   a_nibble_read: assert property (s_axi_rvalid && !rd_status |->
      s_axi_rdata[31:4] == 28'h0) else $error("read data above nibble");
   a_status_width: assert property (s_axi_rvalid && rd_status |->
      s_axi_rdata[31:7] == 25'h0) else $error("status read above its fields");
   a_flag_clear: assert property ($past(aresetn) && $fell(serial_irq_flag) |-> s_axi_bvalid)
      else $error("flag cleared without write");
   a_reset_idle: assert property ($rose(aresetn) |-> sck_out && !so_oe)
      else $error("pins not idle after reset");
   cover property ($rose(serial_irq_flag));
   cover property (sck_oe && $fell(sck_out));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind cssp_serial_port cssp_chk chk
(
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .sck_out, .sck_oe, .so_oe, .serial_irq_flag
);

// File: verification/cssp_peer.sv
// Purpose: far-side serial device
// Assumes: lsb first, bits taken on rising clock
// Notes: makes the clock only in external mode
`timescale 1ns/1ps
module cssp_peer
(
   input wire logic aclk,
   input wire logic go,
   input wire logic ext,
   input wire logic [7:0] tx,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic so_out,
   output logic sck_in,
   output logic si_in,
   output logic [7:0] rx,
   output logic [3:0] rises
);
   logic prev = 1'h1;
   logic [6:0] k = 7'h40;
   logic sck;
   assign sck = sck_oe ? sck_out : sck_in;
   // eight clocks of eight cycles, still and high between frames
   assign sck_in = k[6] | k[2];
   // after the byte the line shows the inverse of the last bit
   assign si_in = rises[3] ? ~tx[7] : tx[rises[2:0]];
   initial rises = 4'h8;
   initial rx = 8'h0;
   always @(posedge aclk)
   begin
      prev <= sck;
      if (go)
         rises <= 4'h0;
      else if (sck && !prev)
      begin
         rises <= rises + 4'h1;
         rx <= {so_out, rx[7:1]};
      end
      if (ext)
         k <= 7'h0;
      else if (!k[6])
         k <= k + 7'h1;
   end
endmodule

// File: verification/cssp_serial_port_tb.sv
// Purpose: self-checking bench for cssp_serial_port
// Assumes: byte address is four times the index
// Notes: peer model sits on the serial pins
`timescale 1ns/1ps
`include "cssp_params.svh"
module cssp_serial_port_tb;
   localparam logic [11:0] ST = `CSSP_IDX_STATUS;
   localparam logic [11:0] CA = `CSSP_IDX_CTRL_A;
   localparam logic [11:0] LO = `CSSP_IDX_DATA_LO;
   localparam logic [11:0] HI = `CSSP_IDX_DATA_HI;
   logic aclk = '0, aresetn = '0, go = '0, ext = '0;
   logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hf, rises;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic sck_in, sck_out, sck_oe, si_in, so_out, so_oe, serial_irq_flag;
   logic [7:0] tx = '0, rx;
   int err_total = 0, cmp_count = 0, cyc = 0, t0;
   cssp_serial_port uut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out, .sck_oe,
      .si_in, .so_out, .so_oe, .serial_irq_flag
   );
   cssp_peer peer
   (
      .aclk, .go, .ext, .tx, .sck_out, .sck_oe, .so_out, .sck_in, .si_in, .rx, .rises
   );
   initial forever #25 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= '0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= '0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= '0;
   endtask
   task automatic rd(input logic [11:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= '0;
      end while (!s_axi_rvalid);
      q = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= '0;
   endtask
   task automatic rc(input logic [11:0] i, input logic [31:0] e, input string n);
      rd(i);
      chk(n, q, e);
   endtask
   task automatic run(input logic [3:0] pm, input logic [3:0] ca, input logic [7:0] d,
      input logic e);
      wr(`CSSP_IDX_PORT_FUNC, 32'(pm));
      wr(CA, 32'(ca));
      wr(LO, 32'(d[3:0]));
      wr(HI, 32'(d[7:4]));
      go <= 1'h1;
      @(posedge aclk);
      go <= '0;
      wr(`CSSP_IDX_CMD, 32'h1);
      ext <= e;
      @(posedge aclk);
      ext <= '0;
   endtask
   task automatic fall();
      logic p;
      do
      begin
         p = sck_out;
         @(posedge aclk);
      end while (!(p && !sck_out));
   endtask
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rc(ST, 32'h0, "status");
      rc(CA, 32'h0, "ctrl_a");
      wr(12'h3ff, 32'h1);
      chk("bresp", 32'(rs), 32'(`CSSP_RESP_SLVERR));
      rd(12'h3ff);
      chk("rresp", 32'(rs), 32'(`CSSP_RESP_SLVERR));
      wr(LO, 32'h5);
      wr(HI, 32'ha);
      s_axi_wstrb <= 4'he;
      wr(LO, 32'h9);
      s_axi_wstrb <= 4'hf;
      rc(LO, 32'h5, "lo");
      rc(HI, 32'ha, "hi");
      $display("registers done");
      tx <= 8'hc3;
      run(4'h3, 4'he, 8'h5a, '0);
      chk("sck_oe", 32'(sck_oe), 32'h1);
      while (!serial_irq_flag) @(posedge aclk);
      repeat (20) @(posedge aclk);
      chk("rx", 32'(rx), 32'h5a);
      chk("rises", 32'(rises), 32'h8);
      rc(LO, 32'h3, "rx_lo");
      rc(HI, 32'hc, "rx_hi");
      rc(ST, 32'h1, "done");
      wr(ST, 32'h4);
      rc(ST, 32'h0, "clear");
      $display("system clock transfer done");
      tx <= 8'h96;
      run(4'h2, 4'hf, 8'h0, 1'h1);
      chk("ext_oe", 32'(sck_oe), 32'h0);
      while (!serial_irq_flag) @(posedge aclk);
      rc(LO, 32'h6, "ext_lo");
      rc(HI, 32'h9, "ext_hi");
      rc(ST, 32'h21, "ext_wait");
      wr(CA, 32'hf);
      rc(ST, 32'h1, "reinit");
      wr(ST, 32'h4);
      $display("external clock transfer done");
      run(4'h0, 4'he, 8'h0, '0);
      repeat (10) @(posedge aclk);
      rd(ST);
      chk("cont", 32'(q[6:5]), 32'h3);
      wr(CA, 32'he);
      rc(ST, 32'h0, "cont_end");
      run(4'h1, 4'hc, 8'hff, '0);
      while (rises != 4'h3) @(posedge aclk);
      rc(ST, 32'h4c, "mid");
      chk("so_oe", 32'(so_oe), 32'h1);
      wr(CA, 32'hc);
      repeat (40) @(posedge aclk);
      chk("stopped", 32'(rises), 32'h3);
      rc(ST, 32'h1, "abort");
      wr(ST, 32'h4);
      wr(`CSSP_IDX_CTRL_B, 32'h2);
      chk("so_hi", 32'({so_oe, so_out}), 32'h3);
      wr(`CSSP_IDX_CTRL_B, 32'h0);
      chk("so_lo", 32'({so_oe, so_out}), 32'h2);
      $display("abort and idle level done");
      for (int b = 0; b < 2; b++)
         for (int c = 0; c < 6; c++)
         begin
            wr(`CSSP_IDX_CTRL_B, 32'(b));
            wr(CA, 32'(8 + c));
            wr(`CSSP_IDX_CMD, 32'h1);
            fall();
            t0 = cyc;
            fall();
            chk("period", 32'(cyc - t0), 32'((4096 >> (2 * c)) << b));
            wr(CA, 32'(8 + c));
            wr(ST, 32'h4);
         end
      $display("prescaler done");
      tally_and_finish();
   end
endmodule
